/* File: codec_ctrl_pkg.sv */
package codec_ctrl_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam int REG_COUNT = 8;
    localparam logic [2:0] ADDR_MODE_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RATE_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_POWER_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_GAIN_MUTE_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_DAC_ADVANCE_BYPASS_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_ANALOG_TAP_CONTROL = 3'h5;
    localparam logic [2:0] ADDR_DIGITAL_TAP_COEFF_LOW = 3'h6;
    localparam logic [2:0] ADDR_DIGITAL_TAP_COEFF_HIGH = 3'h7;
    localparam logic [2:0] OWN_DEVICE_ADDR = 3'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_OPSEL_BIT = 0;
    localparam int MODE_MIXED_BIT = 1;
    localparam int MODE_SOFT_RESET_BIT = 7;
    localparam int POWER_GLOBAL_BIT = 0;
    localparam int POWER_SECTION_LSB = 1;
    localparam int POWER_SECTION_COUNT = 4;
    localparam int POWER_REF_BIT = 5;
    localparam int POWER_REF_MSB = 7;
    localparam int GAIN_IN_LSB = 0;
    localparam int GAIN_MODRST_BIT = 3;
    localparam int GAIN_OUT_LSB = 4;
    localparam int GAIN_MUTE_BIT = 7;
    localparam int DACADV_LSB = 0;
    localparam int DACADV_BYPASS_BIT = 5;
    localparam int DACADV_DTAP_EN_BIT = 6;
    localparam int DACADV_RESERVED_BIT = 7;
    localparam int ATAP_COEFF_LSB = 0;
    localparam int ATAP_SE_EN_BIT = 5;
    localparam int ATAP_INV_BIT = 6;
    localparam int ATAP_LOOP_BIT = 7;

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] RESET_CYCLES = 3'h4;
    localparam int SCLK_DIV = 8;
    localparam int FSYNC_DIV = 2048;

    // ------------------------------------------------------------
    // Control word carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic is_control;
        logic is_read;
        logic [2:0] device_addr;
        logic [2:0] reg_addr;
        logic [7:0] reg_data;
    } ctrl_word_t;

endpackage

/* File: codec_ctrl_regs.sv */
`timescale 1ns/1ps
// How it works
// (R1) Reset pin low clears every control register to zero.
// (R2) Zeroed registers give serial clock at clock/8 and sample rate at clock/2048.
// (R3) Writing one to mode register bit 7 causes a software reset.
// (R4) Hardware or software reset lasts four clock cycles.
// (R5) Reset clears operating mode bit, leaving program mode.
// (R6) First frame sync comes 2048 cycles after reset pin rises.
// (R7) Host ignores output words until data or mixed mode is set.
// (R8) Global power bit powers every section, overriding individual bits.
// (R9) With global bit clear, sections with their own bit set stay powered.
// (R10) Reference bits of both codec units are ORed to enable shared reference.
// (R11) Gain register holds input gain, modulator reset, output gain fields.
// (R12) Gain register bit 7 mutes the output when set.
// (R13) DAC advance register holds a five-bit advance in bits 4:0.
// (R14) DAC advance register bit 5 bypasses the interpolator when set.
// (R15) DAC advance register bit 6 enables the digital gain tap.
// (R16) Software writes zero to reserved DAC advance register bit 7.
// (R17) Analog tap register holds a five-bit coefficient in bits 4:0.
// (R18) Analog tap bit 5 enables single-ended input and analog tap.
// (R19) Analog tap bit 6 inverts the input when set.
// (R20) Analog tap bit 7 enables loopback and analog tap mute.
// (R21) Digital tap coefficient low byte in register 6, high byte in register 7.
// (R22) Control word bits 10:8 select one of eight registers.
// (R23) Power register bit 0 is global power, bit 5 reference power.
// (R24) Mode register bit 0 selects program (0) or data (1) mode.
// (R25) Registers stay zero through reset and take writes only afterwards.
module codec_ctrl_regs #(
    parameter int SCLK_DIVIDE = codec_ctrl_pkg::SCLK_DIV,
    parameter int FSYNC_DIVIDE = codec_ctrl_pkg::FSYNC_DIV
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Control word from the serial framing logic
    input wire codec_ctrl_pkg::ctrl_word_t CTRL_WORD_I,
    input wire logic CTRL_VALID_I,
    // Reference bits of the partner codec unit
    input wire logic [2:0] PEER_REF_BITS_I,
    // Readback
    output logic [7:0] READ_DATA_O,
    output logic READ_VALID_O,
    // Reset and timing
    output logic RESET_BUSY_O,
    output logic SCLK_EN_O,
    output logic FRAME_SYNC_O,
    // Mode
    output logic OPERATING_MODE_O,
    output logic MIXED_MODE_O,
    // Power
    output logic [3:0] SECTION_POWER_O,
    output logic REF_POWER_O,
    output logic [2:0] OWN_REF_BITS_O,
    // Gain and mute
    output logic [2:0] INPUT_GAIN_SELECT_O,
    output logic MODULATOR_RESET_O,
    output logic [2:0] OUTPUT_GAIN_SELECT_O,
    output logic OUTPUT_MUTE_O,
    // DAC advance and digital tap
    output logic [4:0] DAC_ADVANCE_O,
    output logic INTERPOLATOR_BYPASS_O,
    output logic DIGITAL_TAP_ENABLE_O,
    output logic [15:0] DIGITAL_TAP_COEFF_O,
    // Analog tap
    output logic [4:0] ANALOG_TAP_COEFF_O,
    output logic SINGLE_ENDED_ENABLE_O,
    output logic ANALOG_TAP_ENABLE_O,
    output logic INPUT_POLARITY_FLIP_O,
    output logic ANALOG_LOOPBACK_O,
    output logic ANALOG_TAP_MUTE_O
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hits_reg(input codec_ctrl_pkg::ctrl_word_t w, input logic [2:0] a);
        hits_reg = (w.reg_addr == a);
    endfunction

    logic [7:0] regs_reg [codec_ctrl_pkg::REG_COUNT];
    logic [2:0] rst_cnt_reg;
    logic [2:0] rst_cnt_next;
    logic busy_reg;
    logic [$clog2(SCLK_DIVIDE)-1:0] sclk_cnt_reg;
    logic [$clog2(FSYNC_DIVIDE)-1:0] fs_cnt_reg;
    logic [3:0] section_power_next;

    wire logic busy = busy_reg;
    wire logic mode_data = regs_reg[codec_ctrl_pkg::ADDR_MODE_CONTROL][codec_ctrl_pkg::MODE_OPSEL_BIT];
    wire logic mode_mixed = regs_reg[codec_ctrl_pkg::ADDR_MODE_CONTROL][codec_ctrl_pkg::MODE_MIXED_BIT];
    // Program mode, or data with mixed mode, accepts control words
    wire logic cfg_open = !mode_data || mode_mixed; // R24
    wire logic accept = CTRL_VALID_I && CTRL_WORD_I.is_control && !busy && cfg_open
        && (CTRL_WORD_I.device_addr == codec_ctrl_pkg::OWN_DEVICE_ADDR); // R25
    wire logic wr_en = accept && !CTRL_WORD_I.is_read;
    wire logic rd_en = accept && CTRL_WORD_I.is_read;
    wire logic soft_rst = wr_en && hits_reg(CTRL_WORD_I, codec_ctrl_pkg::ADDR_MODE_CONTROL)
        && CTRL_WORD_I.reg_data[codec_ctrl_pkg::MODE_SOFT_RESET_BIT]; // R3
    // Reserved bit forced low so a careless write cannot leave it set
    wire logic [7:0] wr_data = hits_reg(CTRL_WORD_I, codec_ctrl_pkg::ADDR_DAC_ADVANCE_BYPASS_CONTROL)
        ? (CTRL_WORD_I.reg_data & 8'h7F) : CTRL_WORD_I.reg_data; // R16
    wire logic [7:0] power_reg = regs_reg[codec_ctrl_pkg::ADDR_POWER_CONTROL];
    wire logic global_on = power_reg[codec_ctrl_pkg::POWER_GLOBAL_BIT]; // R23
    wire logic [2:0] own_ref = power_reg[codec_ctrl_pkg::POWER_REF_MSB:codec_ctrl_pkg::POWER_REF_BIT];
    wire logic ref_next = global_on || (|own_ref) || (|PEER_REF_BITS_I); // R8 R9 R10

    assign rst_cnt_next = (!RST_N_I || soft_rst) ? codec_ctrl_pkg::RESET_CYCLES
        : (busy ? rst_cnt_reg - 3'h1 : 3'h0); // R4

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I || soft_rst) begin
            for (int i = 0; i < codec_ctrl_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= codec_ctrl_pkg::REG_RESET; // R1 R3 R5
            end
        end else if (wr_en) begin
            regs_reg[CTRL_WORD_I.reg_addr] <= wr_data; // R22
        end
    end

    // Busy taken from the next count so the pin comes straight from a flop
    always_ff @(posedge REF_CLK_I) begin
        rst_cnt_reg <= rst_cnt_next; // R4
        busy_reg <= (rst_cnt_next != 3'h0); // R4 R25
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            READ_DATA_O <= 8'h00;
            READ_VALID_O <= 1'b0;
        end else begin
            READ_VALID_O <= rd_en;
            if (rd_en) begin
                READ_DATA_O <= regs_reg[CTRL_WORD_I.reg_addr]; // R22
            end
        end
    end

    // ------------------------------------------------------------
    // Default rate dividers
    // ------------------------------------------------------------
    // Only the post-reset rates are modelled; rate programming lives elsewhere
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sclk_cnt_reg <= '0;
            fs_cnt_reg <= '0;
            SCLK_EN_O <= 1'b0;
            FRAME_SYNC_O <= 1'b0;
        end else begin
            sclk_cnt_reg <= sclk_cnt_reg + 1'b1;
            fs_cnt_reg <= fs_cnt_reg + 1'b1;
            SCLK_EN_O <= (sclk_cnt_reg == SCLK_DIVIDE[$clog2(SCLK_DIVIDE)-1:0] - 1'b1); // R2
            FRAME_SYNC_O <= (fs_cnt_reg == FSYNC_DIVIDE[$clog2(FSYNC_DIVIDE)-1:0] - 1'b1); // R2 R6
        end
    end

    // ------------------------------------------------------------
    // Power management
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < codec_ctrl_pkg::POWER_SECTION_COUNT; g++) begin : g_sect
            assign section_power_next[g] = global_on || power_reg[codec_ctrl_pkg::POWER_SECTION_LSB + g]; // R8 R9
        end
    endgenerate

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            SECTION_POWER_O <= 4'h0;
            REF_POWER_O <= 1'b0;
        end else begin
            SECTION_POWER_O <= section_power_next;
            REF_POWER_O <= ref_next; // R10
        end
    end

    // ------------------------------------------------------------
    // Field outputs, straight from the register flops
    // ------------------------------------------------------------
    assign RESET_BUSY_O = busy;
    assign OPERATING_MODE_O = mode_data; // R5 R24
    assign MIXED_MODE_O = mode_mixed;
    assign OWN_REF_BITS_O = own_ref;
    assign INPUT_GAIN_SELECT_O = regs_reg[3][codec_ctrl_pkg::GAIN_IN_LSB +: 3]; // R11
    assign MODULATOR_RESET_O = regs_reg[3][codec_ctrl_pkg::GAIN_MODRST_BIT]; // R11
    assign OUTPUT_GAIN_SELECT_O = regs_reg[3][codec_ctrl_pkg::GAIN_OUT_LSB +: 3]; // R11
    assign OUTPUT_MUTE_O = regs_reg[3][codec_ctrl_pkg::GAIN_MUTE_BIT]; // R12
    assign DAC_ADVANCE_O = regs_reg[4][codec_ctrl_pkg::DACADV_LSB +: 5]; // R13
    assign INTERPOLATOR_BYPASS_O = regs_reg[4][codec_ctrl_pkg::DACADV_BYPASS_BIT]; // R14
    assign DIGITAL_TAP_ENABLE_O = regs_reg[4][codec_ctrl_pkg::DACADV_DTAP_EN_BIT]; // R15
    assign ANALOG_TAP_COEFF_O = regs_reg[5][codec_ctrl_pkg::ATAP_COEFF_LSB +: 5]; // R17
    assign SINGLE_ENDED_ENABLE_O = regs_reg[5][codec_ctrl_pkg::ATAP_SE_EN_BIT]; // R18
    assign ANALOG_TAP_ENABLE_O = regs_reg[5][codec_ctrl_pkg::ATAP_SE_EN_BIT]; // R18
    assign INPUT_POLARITY_FLIP_O = regs_reg[5][codec_ctrl_pkg::ATAP_INV_BIT]; // R19
    assign ANALOG_LOOPBACK_O = regs_reg[5][codec_ctrl_pkg::ATAP_LOOP_BIT]; // R20
    assign ANALOG_TAP_MUTE_O = regs_reg[5][codec_ctrl_pkg::ATAP_LOOP_BIT]; // R20
    assign DIGITAL_TAP_COEFF_O = {regs_reg[7], regs_reg[6]}; // R21

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [11:0] rel_cnt_reg;
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            rel_cnt_reg <= 12'h000;
        end else if (rel_cnt_reg != 12'hFFF) begin
            rel_cnt_reg <= rel_cnt_reg + 12'h001;
        end
    end

    wire logic all_zero = (regs_reg[0] == 8'h00) && (regs_reg[1] == 8'h00) && (regs_reg[2] == 8'h00)
        && (regs_reg[3] == 8'h00) && (regs_reg[4] == 8'h00) && (regs_reg[5] == 8'h00)
        && (regs_reg[6] == 8'h00) && (regs_reg[7] == 8'h00);
    wire logic [63:0] bank_flat = {regs_reg[7], regs_reg[6], regs_reg[5], regs_reg[4], regs_reg[3], regs_reg[2],
        regs_reg[1], regs_reg[0]};
    wire logic [7:0] rd_pick = regs_reg[CTRL_WORD_I.reg_addr];

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence reset_window_s;
        RESET_BUSY_O && all_zero [*4];
    endsequence
    sequence reset_done_s;
        !RESET_BUSY_O;
    endsequence

    hw_reset_clear_a: assert property (disable iff (1'b0) !RST_N_I |=> all_zero && RESET_BUSY_O) // R1
        else $error("registers not cleared by reset pin");
    soft_reset_clear_a: assert property (soft_rst |=> reset_window_s ##1 reset_done_s) // R3
        else $error("software reset did not clear registers");
    reset_length_a: assert property ($rose(RST_N_I) |-> reset_window_s ##1 reset_done_s) // R4
        else $error("reset interval not four cycles");
    mode_after_reset_a: assert property ($rose(RST_N_I) |-> !OPERATING_MODE_O ##4 !OPERATING_MODE_O) // R5
        else $error("operating mode not program after reset");
    fsync_early_a: assert property (rel_cnt_reg < 12'd2048 |-> !FRAME_SYNC_O) // R6
        else $error("frame sync before 2048 cycles");
    fsync_first_a: assert property (rel_cnt_reg == 12'd2048 |-> FRAME_SYNC_O) // R6
        else $error("frame sync missing at 2048 cycles");
    sclk_rate_a: assert property (SCLK_EN_O |=> !SCLK_EN_O [*7] ##1 SCLK_EN_O) // R2
        else $error("serial clock enable not every 8 cycles");
    global_power_a: assert property (global_on |=> SECTION_POWER_O == 4'hF && REF_POWER_O) // R8
        else $error("global power did not override sections");
    ref_hold_a: assert property (!global_on && power_reg[5] |=> REF_POWER_O) // R9
        else $error("reference dropped with own bit set");
    ref_peer_a: assert property ((|PEER_REF_BITS_I) |=> REF_POWER_O) // R10
        else $error("peer reference bits not ORed in");
    gain_write_a: assert property (wr_en && hits_reg(CTRL_WORD_I, 3'h3) // R11
        |=> {OUTPUT_MUTE_O, OUTPUT_GAIN_SELECT_O, MODULATOR_RESET_O, INPUT_GAIN_SELECT_O}
            == $past(CTRL_WORD_I.reg_data))
        else $error("gain register fields misplaced");
    dtap_high_a: assert property (wr_en && hits_reg(CTRL_WORD_I, 3'h7) // R21
        |=> DIGITAL_TAP_COEFF_O[15:8] == $past(CTRL_WORD_I.reg_data))
        else $error("digital tap high byte misplaced");
    busy_block_a: assert property (RESET_BUSY_O |=> all_zero) // R25
        else $error("register changed during reset interval");

    // ------------------------------------------------------------
    // Field and access assertions
    // ------------------------------------------------------------
    mute_write_a: assert property (wr_en && hits_reg(CTRL_WORD_I, codec_ctrl_pkg::ADDR_GAIN_MUTE_CONTROL) // R12
        |=> OUTPUT_MUTE_O == $past(CTRL_WORD_I.reg_data[codec_ctrl_pkg::GAIN_MUTE_BIT]))
        else $error("mute bit misplaced");
    dac_adv_write_a: assert property (wr_en && hits_reg(CTRL_WORD_I, 3'h4) // R13 R14 R15 R16
        |=> {DIGITAL_TAP_ENABLE_O, INTERPOLATOR_BYPASS_O, DAC_ADVANCE_O} == $past(CTRL_WORD_I.reg_data[6:0])
            && !regs_reg[4][codec_ctrl_pkg::DACADV_RESERVED_BIT])
        else $error("DAC advance register fields misplaced");
    atap_write_a: assert property (wr_en && hits_reg(CTRL_WORD_I, 3'h5) // R17 R18 R19 R20
        |=> {ANALOG_TAP_MUTE_O, ANALOG_LOOPBACK_O, INPUT_POLARITY_FLIP_O, ANALOG_TAP_ENABLE_O, SINGLE_ENDED_ENABLE_O}
            == {{2{$past(CTRL_WORD_I.reg_data[7])}}, $past(CTRL_WORD_I.reg_data[6]),
            {2{$past(CTRL_WORD_I.reg_data[5])}}}
            && ANALOG_TAP_COEFF_O == $past(CTRL_WORD_I.reg_data[4:0]))
        else $error("analog tap register fields misplaced");
    dtap_low_a: assert property (wr_en && hits_reg(CTRL_WORD_I, 3'h6) // R21
        |=> DIGITAL_TAP_COEFF_O[7:0] == $past(CTRL_WORD_I.reg_data))
        else $error("digital tap low byte misplaced");
    mode_write_a: assert property (wr_en && hits_reg(CTRL_WORD_I, 3'h0) && !soft_rst // R24
        |=> {MIXED_MODE_O, OPERATING_MODE_O} == $past(CTRL_WORD_I.reg_data[1:0]))
        else $error("mode bits misplaced");
    read_data_a: assert property (rd_en // R22
        |=> READ_VALID_O && READ_DATA_O == $past(rd_pick))
        else $error("read returned wrong register");
    read_pulse_a: assert property (!rd_en // R22
        |=> !READ_VALID_O)
        else $error("read valid without accepted read");
    // Refused words must leave the bank untouched
    bank_hold_a: assert property (!wr_en // R25
        |=> $stable(bank_flat))
        else $error("register changed without accepted write");
    // Pure data mode is left only through the reset pin
    data_lock_a: assert property (mode_data && !mode_mixed // R24
        |=> $stable(bank_flat))
        else $error("bank written in pure data mode");
    section_follow_a: assert property (!global_on // R9 R23
        |=> SECTION_POWER_O == $past(power_reg[codec_ctrl_pkg::POWER_SECTION_LSB +: 4]))
        else $error("section power not following own bits");
    ref_off_a: assert property (!global_on && own_ref == 3'h0 && PEER_REF_BITS_I == 3'h0 // R10 R23
        |=> !REF_POWER_O)
        else $error("reference powered with every bit clear");

endmodule

/* File: dsp_ctrl_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side control word source
// ------------------------------------------------------------
module dsp_ctrl_model (
    // Clock
    input wire logic clk_i,
    // Control word toward the register bank
    output codec_ctrl_pkg::ctrl_word_t word_o,
    output logic valid_o
);
    initial begin
        word_o = 16'hA5C3;
        valid_o = 1'b0;
    end

    // Called at a falling edge; the word is held over exactly one rising edge
    task automatic put(input logic [15:0] w);
        logic clr;
        clr = !w[14] && w[10:8] == codec_ctrl_pkg::ADDR_DAC_ADVANCE_BYPASS_CONTROL;
        word_o = {w[15:8], w[7] & !clr, w[6:0]};
        valid_o = 1'b1;
        @(negedge clk_i);
        valid_o = 1'b0;
        // Released bus never shows the stale word
        word_o = ~word_o;
    endtask
endmodule

/* File: codec_control_regs_reset_power_bench.sv */
`timescale 1ns/1ps
module codec_control_regs_reset_power_bench;
    logic clk;
    logic rst_n;
    logic [2:0] peer;
    codec_ctrl_pkg::ctrl_word_t word;
    logic valid, rv, busy, sclk, fsync, opm, mixm, refp;
    logic [7:0] rdata;
    logic [3:0] sect;
    logic [2:0] ownref;
    logic [2:0] a;
    wire [40:0] act;
    logic [7:0] sh [8];
    logic [31:0] seed, r;
    logic [10:0] cw [6] = '{11'h201, 11'h220, 11'h6FF, 11'h780, 11'h4FF, 11'h5A0};
    int n_fail, n_compared, run, last_run;

    dsp_ctrl_model dsp_inst (.clk_i(clk), .word_o(word), .valid_o(valid));

    codec_ctrl_regs codec_ctrl_regs_inst (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .CTRL_WORD_I(word), .CTRL_VALID_I(valid), .PEER_REF_BITS_I(peer),
        .READ_DATA_O(rdata), .READ_VALID_O(rv), .RESET_BUSY_O(busy), .SCLK_EN_O(sclk), .FRAME_SYNC_O(fsync),
        .OPERATING_MODE_O(opm), .MIXED_MODE_O(mixm), .SECTION_POWER_O(sect), .REF_POWER_O(refp),
        .OWN_REF_BITS_O(ownref), .INPUT_GAIN_SELECT_O(act[40:38]), .MODULATOR_RESET_O(act[37]),
        .OUTPUT_GAIN_SELECT_O(act[36:34]), .OUTPUT_MUTE_O(act[33]), .DAC_ADVANCE_O(act[32:28]),
        .INTERPOLATOR_BYPASS_O(act[27]), .DIGITAL_TAP_ENABLE_O(act[26]), .DIGITAL_TAP_COEFF_O(act[15:0]),
        .ANALOG_TAP_COEFF_O(act[25:21]), .SINGLE_ENDED_ENABLE_O(act[20]), .ANALOG_TAP_ENABLE_O(act[19]),
        .INPUT_POLARITY_FLIP_O(act[18]), .ANALOG_LOOPBACK_O(act[17]), .ANALOG_TAP_MUTE_O(act[16])
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [40:0] expf();
        return {sh[3][2:0], sh[3][3], sh[3][6:4], sh[3][7], sh[4][4:0], sh[4][5], sh[4][6],
                sh[5][4:0], sh[5][5], sh[5][5], sh[5][6], sh[5][7], sh[5][7], sh[7], sh[6]};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Power outputs land one cycle after the register, so look one cycle later
    task automatic chk_all();
        logic g;
        @(negedge clk);
        g = sh[2][0];
        chk(act, expf());
        chk({sect, refp, ownref}, {{4{g}} | sh[2][4:1], g | (|sh[2][7:5]) | (|peer), sh[2][7:5]});
        chk({opm, mixm}, {sh[0][0], sh[0][1]});
    endtask

    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        dsp_inst.put({2'b10, codec_ctrl_pkg::OWN_DEVICE_ADDR, ad, d});
        sh[ad] = (ad == codec_ctrl_pkg::ADDR_DAC_ADVANCE_BYPASS_CONTROL) ? {1'b0, d[6:0]} : d;
    endtask

    task automatic rd(input logic [2:0] ad);
        dsp_inst.put({2'b11, codec_ctrl_pkg::OWN_DEVICE_ADDR, ad, 8'h00});
        chk({rv, rdata}, {1'b1, sh[ad]});
        @(negedge clk);
        chk(rv, 1'b0);
    endtask

    task automatic do_reset();
        int nb;
        int fs;
        int sc;
        nb = 0;
        fs = -1;
        sc = -1;
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        sh = '{default: 8'h00};
        // Index 0 is the falling edge at which reset is let go
        for (int m = 0; m < 2100; m++) begin
            if (busy === 1'b1 && m < 10) nb++;
            if (sclk === 1'b1 && sc < 0) sc = m;
            if (fsync === 1'b1 && fs < 0) fs = m;
            @(negedge clk);
        end
        chk(nb, 4);
        chk(sc, 8);
        chk(fs, 2048);
        chk_all();
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Length of the last busy run, used after a software reset
    always @(negedge clk) begin
        if (busy === 1'b1) begin
            run++;
        end else if (run != 0) begin
            last_run = run;
            run = 0;
        end
    end

    initial begin
        #(20 * 20000);
        n_fail++;
        final_report();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        peer = 3'h0;
        seed = 32'h157;
        n_fail = 0;
        n_compared = 0;
        run = 0;
        last_run = 0;
        do_reset();
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wr(cw[i][10:8], cw[i][7:0]);
            chk_all();
        end
        for (int i = 0; i < 40; i++) begin
            r = nxt();
            peer = r[30:28];
            a = (r[10:8] < 3'h2) ? r[10:8] + 3'h2 : r[10:8];
            wr(a, r[7:0]);
            chk_all();
            rd(r[18:16]);
        end
        $display("test random done");
        // Wrong device address, then a data word: both ignored
        dsp_inst.put({2'b10, 3'h1, 3'h3, ~sh[3]});
        chk_all();
        dsp_inst.put({2'b00, 3'h0, 3'h3, ~sh[3]});
        chk_all();
        // Pure data mode locks the bank until a pin reset
        wr(3'h0, 8'h01);
        chk_all();
        dsp_inst.put({2'b10, 3'h0, 3'h3, ~sh[3]});
        chk_all();
        do_reset();
        wr(3'h0, 8'h03);
        chk_all();
        wr(3'h3, 8'h5A);
        chk_all();
        $display("test modes done");
        dsp_inst.put({2'b10, 3'h0, 3'h0, 8'h80});
        @(negedge clk);
        dsp_inst.put({2'b10, 3'h0, 3'h3, 8'hFF});
        sh = '{default: 8'h00};
        for (int k = 0; k < 8 && busy !== 1'b0; k++) @(negedge clk);
        chk_all();
        chk(last_run, 4);
        $display("test soft reset done");
        final_report();
    end
endmodule
